/* File: hw/sbmt_mem_target.v */
// memory target agent on a split-transaction tagged system bus
`timescale 1ns/100ps
`include "sbmt_defines.vh"
module sbmt_mem_target (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire addr_valid_i,
  input wire [4:0] addr_op_i,
  input wire [`SBMT_AW-1:0] addr_i,
  input wire addr_par_i,
  input wire [`SBMT_TW-1:0] addr_tag_i,
  input wire addr_guarded_i,
  input wire [1:0] combined_addr_status_in_i,
  input wire [1:0] combined_addr_response_in_i,
  input wire data_in_valid_i,
  input wire [`SBMT_DW-1:0] data_in_i,
  input wire [`SBMT_TW-1:0] data_in_tag_i,
  input wire pos_ack_en_i,
  input wire par_check_en_i,
  input wire [`SBMT_AW-1:0] space_base_i,
  input wire [`SBMT_AW-1:0] space_mask_i,
  output reg [1:0] agent_addr_status_out_o,
  output reg [1:0] agent_addr_response_out_o,
  output reg data_valid_strobe_o,
  output reg [`SBMT_TW-1:0] data_tag_o,
  output reg [`SBMT_DW-1:0] data_out_o,
  output reg busy_o
);
  // ==========================================================
  // input synchronisers
  // ==========================================================
  // every pin, data bus included, costs two clocks of latency; all bus
  // windows below count from the synchronised copy, so the status
  // answer leaves three clocks after the tenure is on the pins
  localparam SW = 1 + 5 + `SBMT_AW + 1 + `SBMT_TW + 1 + 4 + 1
    + `SBMT_DW + `SBMT_TW + 2 + `SBMT_AW + `SBMT_AW;
  wire [SW-1:0] raw_w;
  wire [SW-1:0] syn_w;
  wire s_av;
  wire [4:0] s_op;
  wire [`SBMT_AW-1:0] s_addr;
  wire s_par;
  wire [`SBMT_TW-1:0] s_tag;
  wire s_grd;
  wire [1:0] s_stat;
  wire [1:0] s_resp;
  wire s_dv;
  wire [`SBMT_DW-1:0] s_din;
  wire [`SBMT_TW-1:0] s_dtag;
  wire s_ack_en;
  wire s_par_en;
  wire [`SBMT_AW-1:0] s_base;
  wire [`SBMT_AW-1:0] s_mask;
  assign raw_w = {addr_valid_i, addr_op_i, addr_i, addr_par_i, addr_tag_i,
    addr_guarded_i, combined_addr_status_in_i, combined_addr_response_in_i,
    data_in_valid_i, data_in_i, data_in_tag_i, pos_ack_en_i, par_check_en_i,
    space_base_i, space_mask_i};
  assign {s_av, s_op, s_addr, s_par, s_tag, s_grd, s_stat, s_resp, s_dv,
    s_din, s_dtag, s_ack_en, s_par_en, s_base, s_mask} = syn_w;
  sbmt_sync2 #(.W(SW)) u_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i(raw_w),
    .q_o(syn_w)
  );

  // ==========================================================
  // address decode
  // ==========================================================
  // one operation in flight at a time; the state says which window of
  // the tenure it has reached
  localparam ST_IDLE = 3'h0;
  localparam ST_STAT = 3'h1;
  localparam ST_RESP = 3'h2;
  localparam ST_READ = 3'h3;
  localparam ST_WRITE = 3'h4;
  localparam ST_ABORT = 3'h5;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  // the reissue flag (bit 7) gets no special handling; it is decoded as an ordinary block index bit of blk_ff
  wire hit_w = ((s_addr ^ s_base) & s_mask) == {`SBMT_AW{1'b0}};
  wire is_rd_w = (s_op == `SBMT_OP_READ) || (s_op == `SBMT_OP_RFO);
  wire is_wr_w = (s_op == `SBMT_OP_WR_KILL) ||
    (s_op == `SBMT_OP_WR_CLEAN) || (s_op == `SBMT_OP_WR_FLUSH);
  // barriers need no work since nothing is reordered; deferred
  // completions fall outside take_w and are dropped
  wire is_nop_w = (s_op == `SBMT_OP_SYNC) ||
    (s_op == `SBMT_OP_IO_BARRIER);
  wire par_bad_w = s_par_en && ((^s_addr) != s_par);
  wire take_w = s_av && hit_w && (is_rd_w || is_wr_w || is_nop_w);

  // ==========================================================
  // operation capture
  // ==========================================================
  // captured at the start of an operation and held until it ends;
  // nothing here is read again once the state returns to idle
  reg is_rd_ff;
  reg is_flush_ff;
  reg grd_ff;
  reg [`SBMT_TW-1:0] tag_ff;
  reg [`SBMT_MEM_AW-1:0] blk_ff;
  reg [1:0] qw_ff;
  reg [1:0] beat_ff;
  reg [2:0] wait_ff;
  reg resp_ok_ff;
  reg [`SBMT_DW-1:0] mem_ff [0:(1<<(`SBMT_MEM_AW+2))-1];
  reg [`SBMT_DW-1:0] wbuf_ff [0:3];
  reg [3:0] wgot_ff;
  wire [1:0] qw_now_w = qw_ff + beat_ff;
  wire [`SBMT_MEM_AW+1:0] midx_w = {blk_ff, qw_now_w};
  // a deferred reply counts as retry; modified also ends a read since
  // the data now comes from a cache
  wire retry_resp_w = (s_resp == `SBMT_RS_RETRY) ||
    (s_resp == `SBMT_RS_DEFERRED);
  wire kill_resp_w = retry_resp_w || (s_resp == `SBMT_RS_MODIFIED);
  wire stat_abort_w = (s_stat == `SBMT_ST_RETRY) ||
    (s_stat == `SBMT_ST_PARERR);

  // ==========================================================
  // sequencing
  // ==========================================================
  // timeline of one operation, in synchronised clocks:
  //   c0  tenure seen, status answer registered, state to STAT
  //   c1  combined status retry or parity error throws it away
  //   c2  response window opens and runs for three clocks
  //   c3  unguarded reads enter the read state; beats leave from c4
  //   c6  response sampled; a kill ends the beats there
  //   guarded reads and every write wait for c6 before data moves
  // trade-off: early reads save three clocks of latency but a killed
  // one has already spent two data beats on the bus
  // one operation in flight; any other read or write meanwhile is retried unless its address parity fails, while barriers are still acknowledged
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take_w && !par_bad_w && !is_nop_w) begin
          nxt_state = ST_STAT;
        end
      end
      ST_STAT: begin
        if (stat_abort_w) begin
          nxt_state = ST_IDLE;
        end else if (wait_ff == 3'h0) begin
          nxt_state = ST_RESP;
        end
      end
      ST_RESP: begin
        // guarded and flush operations hold until the response is seen
        if (wait_ff == 3'h0) begin
          if (kill_resp_w) begin
            nxt_state = ST_IDLE;
          end else if (is_rd_ff) begin
            nxt_state = ST_READ;
          end else begin
            nxt_state = ST_WRITE;
          end
        end else if (!grd_ff && !is_flush_ff && is_rd_ff) begin
          nxt_state = ST_READ; // unguarded reads start early
        end
      end
      ST_READ: begin
        if (!resp_ok_ff && wait_ff == 3'h0 && kill_resp_w) begin
          nxt_state = ST_ABORT;
        end else if (beat_ff == `SBMT_BEATS) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (wgot_ff == 4'hf) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ABORT: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
      is_rd_ff <= 1'b0;
      is_flush_ff <= 1'b0;
      grd_ff <= 1'b0;
      tag_ff <= {`SBMT_TW{1'b0}};
      blk_ff <= {`SBMT_MEM_AW{1'b0}};
      qw_ff <= 2'h0;
      beat_ff <= 2'h0;
      wait_ff <= 3'h0;
      resp_ok_ff <= 1'b0;
      wgot_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      if (wait_ff != 3'h0) begin
        wait_ff <= wait_ff - 3'h1;
      end
      case (state_ff)
        ST_IDLE: begin
          if (nxt_state == ST_STAT) begin
            is_rd_ff <= is_rd_w;
            is_flush_ff <= (s_op == `SBMT_OP_WR_FLUSH);
            grd_ff <= s_grd;
            tag_ff <= s_tag;
            blk_ff <= s_addr[`SBMT_MEM_AW+5:6];
            qw_ff <= s_addr[5:4];
            beat_ff <= 2'h0;
            wgot_ff <= 4'h0;
            resp_ok_ff <= 1'b0;
            wait_ff <= `SBMT_STAT_DLY;
          end
        end
        ST_STAT: begin
          if (wait_ff == 3'h0) begin
            wait_ff <= `SBMT_RESP_DLY;
          end
        end
        ST_RESP: begin
          if (wait_ff == 3'h0) begin
            resp_ok_ff <= !kill_resp_w;
          end else if (nxt_state == ST_READ) begin
            wait_ff <= `SBMT_ABORT_DLY - 3'h1;
          end
        end
        ST_READ: begin
          beat_ff <= beat_ff + 2'h1;
          if (wait_ff == 3'h0) begin
            resp_ok_ff <= 1'b1;
          end
        end
        ST_WRITE: begin
          if (s_dv && s_dtag == tag_ff) begin
            wgot_ff[beat_ff] <= 1'b1;
            beat_ff <= beat_ff + 2'h1;
          end
        end
        default: begin
          beat_ff <= 2'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // memory array: write data buffered, committed after full block
  // ==========================================================
  // aborted writes simply never commit, which keeps the array clean
  // the commit lands in the clock after the fourth beat, all four
  // quad-words at once, so a reader never sees half a block
  always @(posedge sys_clk_i) begin
    if (state_ff == ST_WRITE && s_dv && s_dtag == tag_ff) begin
      wbuf_ff[qw_now_w] <= s_din;
    end
    if (state_ff == ST_WRITE && wgot_ff == 4'hf) begin
      mem_ff[{blk_ff, 2'h0}] <= wbuf_ff[0];
      mem_ff[{blk_ff, 2'h1}] <= wbuf_ff[1];
      mem_ff[{blk_ff, 2'h2}] <= wbuf_ff[2];
      mem_ff[{blk_ff, 2'h3}] <= wbuf_ff[3];
    end
  end

  // ==========================================================
  // bus outputs
  // ==========================================================
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      agent_addr_status_out_o <= `SBMT_ST_NULL;
      agent_addr_response_out_o <= `SBMT_RS_NULL;
      data_valid_strobe_o <= 1'b0;
      data_tag_o <= {`SBMT_TW{1'b0}};
      data_out_o <= {`SBMT_DW{1'b0}};
      busy_o <= 1'b0;
    end else begin
      // response output stays null: never deferred, never retried
      agent_addr_response_out_o <= `SBMT_RS_NULL;
      busy_o <= (nxt_state != ST_IDLE);
      // status answers the tenure seen this clock; a parity error wins
      // over retry so that a bad address is never mistaken for flow
      // control
      agent_addr_status_out_o <= `SBMT_ST_NULL;
      if (s_av && hit_w && (is_rd_w || is_wr_w || is_nop_w)) begin
        if (par_bad_w) begin
          agent_addr_status_out_o <= `SBMT_ST_PARERR;
        end else if (state_ff != ST_IDLE && !is_nop_w) begin
          agent_addr_status_out_o <= `SBMT_ST_RETRY;
        end else if (s_ack_en) begin
          agent_addr_status_out_o <= `SBMT_ST_ACK;
        end
      end
      // a killed read simply stops strobing; the tag is dropped too
      if (state_ff == ST_READ && nxt_state == ST_READ ||
          state_ff == ST_READ && nxt_state == ST_IDLE) begin
        data_valid_strobe_o <= 1'b1;
        data_tag_o <= tag_ff;
        data_out_o <= mem_ff[midx_w];
      end else begin
        data_valid_strobe_o <= 1'b0;
        data_tag_o <= {`SBMT_TW{1'b0}};
      end
    end
  end
  // the address request/grant pair is absent: this target never masters
  // the address bus
endmodule // sbmt_mem_target

/* File: hw/sbmt_defines.vh */
// constants for the split-bus memory target
// Notes on behaviour
// - act on reads, ownership reads, writes and barriers only; ignore the rest
// - positively acknowledge operations aimed at our own address space
// - no address bus request or grant handshake is implemented
// - watch retry on both combined status and combined response inputs
// - retry on our status output is the only flow control
// - with acknowledge enabled, drive acknowledge code for our memory space
// - drive parity-error code on status output when address parity fails
// - the response output need not carry any code
// - guarded accesses wait until status and response allow them
// - bursts start at critical quad-word and wrap within the aligned block
// - three cycles after retry or modified response, stop using that tag
// - suppress aborted read data by dropping the data valid strobe
// - a deferred-reply response is handled exactly like retry
// - the reissue flag on address bit 7 is ignored; here bit 7 is still used as a block index bit
// - ownership reads are processed like plain reads
// - write with kill and write with clean are plain writes
// - an aborted write releases its data tag; received data may stay
// - flush write waits on deferred reply, aborts on retry, commits on null; here a deferred reply aborts it like retry
// - this target never reorders, so both barriers are no-ops
// - deferred-reply completion operations from adapters are ignored
// - never drive a deferred-reply code on the response output
`ifndef SBMT_DEFINES_VH
`define SBMT_DEFINES_VH
// bus operation type codes
`define SBMT_OP_READ 5'h01
`define SBMT_OP_RFO 5'h02
`define SBMT_OP_WR_KILL 5'h03
`define SBMT_OP_WR_CLEAN 5'h04
`define SBMT_OP_WR_FLUSH 5'h05
`define SBMT_OP_SYNC 5'h06
`define SBMT_OP_IO_BARRIER 5'h07
`define SBMT_OP_DEFERRED 5'h08
// address status codes
`define SBMT_ST_NULL 2'h0
`define SBMT_ST_ACK 2'h1
`define SBMT_ST_RETRY 2'h2
`define SBMT_ST_PARERR 2'h3
// address response codes
`define SBMT_RS_NULL 2'h0
`define SBMT_RS_RETRY 2'h1
`define SBMT_RS_MODIFIED 2'h2
`define SBMT_RS_DEFERRED 2'h3
// pipeline timing in bus clocks
`define SBMT_STAT_DLY 3'h1
`define SBMT_RESP_DLY 3'h3
`define SBMT_ABORT_DLY 3'h3
// burst geometry: four quad-words per aligned block
`define SBMT_BEATS 2'h3
`define SBMT_REISSUE_BIT 7
`define SBMT_AW 40
`define SBMT_TW 8
`define SBMT_DW 128
`define SBMT_MEM_AW 8
`endif

/* File: hw/sbmt_sync2.v */
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module sbmt_sync2 #(
  parameter W = 1
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  // first stage feeds only the second stage
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end
  assign q_o = sync_ff;
endmodule // sbmt_sync2

/* File: bench/sbmt_checker.sv */
// assertion checker for the split-bus memory target
`timescale 1ns/100ps
`include "sbmt_defines.vh"
module sbmt_checker (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire addr_valid_i,
  input wire [4:0] addr_op_i,
  input wire [`SBMT_AW-1:0] addr_i,
  input wire addr_par_i,
  input wire addr_guarded_i,
  input wire [1:0] combined_addr_response_in_i,
  input wire pos_ack_en_i,
  input wire par_check_en_i,
  input wire [`SBMT_AW-1:0] space_base_i,
  input wire [`SBMT_AW-1:0] space_mask_i,
  input wire [1:0] agent_addr_status_out_o,
  input wire [1:0] agent_addr_response_out_o,
  input wire data_valid_strobe_o,
  input wire [`SBMT_TW-1:0] data_tag_o,
  input wire busy_o
);
  // ========
  // tenure decode at the pins
  wire hit = ((addr_i ^ space_base_i) & space_mask_i) == 40'h0;
  wire sup = addr_op_i != 5'h00 && addr_op_i < 5'h08;
  wire bad_par = par_check_en_i && ((^addr_i) != addr_par_i);
  wire kill = combined_addr_response_in_i != `SBMT_RS_NULL;
  wire take = addr_valid_i && hit && sup;
  wire [1:0] st = agent_addr_status_out_o;
  // ========
  // properties; pins reach the logic two sync stages late
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_busy_hit;
    take && addr_op_i < `SBMT_OP_SYNC && busy_o && !bad_par ##2 busy_o;
  endsequence
  sequence s_clean_start;
    $rose(data_valid_strobe_o) && !kill;
  endsequence
  sequence s_guard_kill;
    take && addr_guarded_i && kill ##1 kill [*7];
  endsequence
  a_resp_quiet: assert property (
    agent_addr_response_out_o == `SBMT_RS_NULL) else $error("resp out");
  a_tag_idle: assert property (
    !data_valid_strobe_o |-> data_tag_o == 8'h0) else $error("idle tag");
  a_ignore_other: assert property (
    addr_valid_i && !sup |-> ##2 (st == `SBMT_ST_NULL) [*3])
    else $error("ignored op answered");
  a_miss_silent: assert property (
    addr_valid_i && !hit |-> ##2 (st == `SBMT_ST_NULL) [*3])
    else $error("miss answered");
  a_ack_hit: assert property (
    take && !bad_par && pos_ack_en_i && !busy_o
    |-> ##[2:4] st == `SBMT_ST_ACK) else $error("no ack");
  a_parity_report: assert property (
    take && bad_par && !busy_o |-> ##[2:4] st == `SBMT_ST_PARERR)
    else $error("no parity code");
  a_busy_retry: assert property (
    s_busy_hit |-> ##[1:3] st == `SBMT_ST_RETRY) else $error("no retry");
  a_burst_whole: assert property (
    s_clean_start |=> (data_valid_strobe_o && $stable(data_tag_o)) [*3]
    ##1 !data_valid_strobe_o) else $error("burst not four beats");
  a_guard_kill: assert property (
    s_guard_kill |=> !data_valid_strobe_o [*4])
    else $error("killed guarded read returned data");
endmodule // sbmt_checker

bind sbmt_mem_target sbmt_checker u_chk (.sys_clk_i, .resetn_i,
  .addr_valid_i, .addr_op_i, .addr_i, .addr_par_i, .addr_guarded_i,
  .combined_addr_response_in_i, .pos_ack_en_i, .par_check_en_i,
  .space_base_i, .space_mask_i, .agent_addr_status_out_o,
  .agent_addr_response_out_o, .data_valid_strobe_o, .data_tag_o, .busy_o);

/* File: bench/sbmt_bus_master.sv */
// bus master and snooper model facing the memory target
`timescale 1ns/100ps
module sbmt_bus_master (
  input wire sys_clk_i,
  input wire strobe_i,
  input wire [7:0] rtag_i,
  input wire [127:0] rdata_i,
  output reg av_o,
  output reg [4:0] op_o,
  output reg [39:0] addr_o,
  output reg par_o,
  output reg [7:0] tag_o,
  output reg grd_o,
  output reg [1:0] st_o,
  output reg [1:0] rs_o,
  output reg dv_o,
  output reg [127:0] d_o,
  output reg [7:0] dt_o
);
  reg [135:0] rq[$];
  // idle bus at time zero
  initial begin
    {av_o, op_o, addr_o, par_o, tag_o, grd_o} = 56'h0;
    {st_o, rs_o, dv_o, d_o, dt_o} = 141'h0;
  end
  // capture every returned beat with its tag
  always @(posedge sys_clk_i) begin
    if (strobe_i) rq.push_back({rtag_i, rdata_i});
  end
  // one tenure; combined status and response stay until quiet
  task tenure(input [4:0] o, input [39:0] a, input [7:0] t, input g,
      input [1:0] s, input [1:0] r, input pb);
    begin
      @(negedge sys_clk_i);
      av_o = 1'b1;
      op_o = o;
      addr_o = a;
      par_o = ^a ^ pb;
      tag_o = t;
      grd_o = g;
      st_o = s;
      rs_o = r;
      @(negedge sys_clk_i);
      av_o = 1'b0;
      addr_o = ~a;
      tag_o = ~t;
    end
  endtask
  task quiet;
    begin
      @(negedge sys_clk_i);
      st_o = 2'h0;
      rs_o = 2'h0;
    end
  endtask
  // write beats go critical quad-word first, wrapping in the block
  task wbeats(input [7:0] t, input [1:0] c, input [511:0] b);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        @(negedge sys_clk_i);
        dv_o = 1'b1;
        dt_o = t;
        d_o = b[128*((c+i)%4) +: 128];
      end
      @(negedge sys_clk_i);
      dv_o = 1'b0;
      d_o = ~d_o;
      dt_o = ~t;
    end
  endtask
endmodule // sbmt_bus_master

/* File: bench/sbmt_mem_target_tb.sv */
// self-checking bench for the split-bus memory target
`timescale 1ns/100ps
`include "sbmt_defines.vh"
module sbmt_mem_target_tb;
  reg sys_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  wire addr_valid_i, addr_par_i, addr_guarded_i, data_in_valid_i;
  wire [4:0] addr_op_i;
  wire [39:0] addr_i;
  wire [7:0] addr_tag_i, data_in_tag_i, data_tag_o;
  wire [1:0] combined_addr_status_in_i, combined_addr_response_in_i;
  wire [127:0] data_in_i, data_out_o;
  wire [1:0] agent_addr_status_out_o, agent_addr_response_out_o;
  wire data_valid_strobe_o, busy_o;
  reg pos_ack_en_i = 1'b1;
  reg par_check_en_i = 1'b1;
  wire [39:0] space_base_i = 40'h0;
  wire [39:0] space_mask_i = 40'hff_ffff_c000;
  integer mismatches = 0, n_checks = 0, cyc = 0, k;
  reg [31:0] lf = 32'hb6cde46f;
  reg [511:0] mem [0:255];
  reg [511:0] blk;
  reg [39:0] ad;
  reg [7:0] tg;
  reg [1:0] st;
  always #5 sys_clk_i = ~sys_clk_i;
  sbmt_mem_target DUT (.sys_clk_i, .resetn_i, .addr_valid_i, .addr_op_i,
    .addr_i, .addr_par_i, .addr_tag_i, .addr_guarded_i,
    .combined_addr_status_in_i, .combined_addr_response_in_i,
    .data_in_valid_i, .data_in_i, .data_in_tag_i, .pos_ack_en_i,
    .par_check_en_i, .space_base_i, .space_mask_i, .agent_addr_status_out_o,
    .agent_addr_response_out_o, .data_valid_strobe_o, .data_tag_o,
    .data_out_o, .busy_o);
  sbmt_bus_master m (.sys_clk_i, .strobe_i(data_valid_strobe_o),
    .rtag_i(data_tag_o), .rdata_i(data_out_o), .av_o(addr_valid_i),
    .op_o(addr_op_i), .addr_o(addr_i), .par_o(addr_par_i),
    .tag_o(addr_tag_i), .grd_o(addr_guarded_i),
    .st_o(combined_addr_status_in_i), .rs_o(combined_addr_response_in_i),
    .dv_o(data_in_valid_i), .d_o(data_in_i), .dt_o(data_in_tag_i));
  // ========
  // expectations and checks
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [1:0] exp_st(input [4:0] o, input [39:0] a, input pb);
    if (o == 5'h00 || o > 5'h07 || a[39:14] != 26'h0) exp_st = 2'h0;
    else if (pb && par_check_en_i) exp_st = `SBMT_ST_PARERR;
    else if (pos_ack_en_i) exp_st = `SBMT_ST_ACK;
    else exp_st = `SBMT_ST_NULL;
  endfunction
  task cmp(input [63:0] nm, input [135:0] e, input [135:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // a tenure, then the first status code seen in a short window
  task go(input [4:0] o, input [39:0] a, input g, input [1:0] s,
      input [1:0] r, input pb);
    integer i;
    begin
      lf = lfsr(lf);
      tg = lf[7:0];
      m.rq.delete();
      m.tenure(o, a, tg, g, s, r, pb);
      st = 2'h0;
      for (i = 0; i < 6; i = i + 1) begin
        @(posedge sys_clk_i);
        #1;
        if (st == 2'h0) st = agent_addr_status_out_o;
      end
    end
  endtask
  task settle;
    integer i;
    begin
      for (i = 0; i < 60 && busy_o !== 1'b0; i = i + 1)
        @(negedge sys_clk_i);
      repeat (3) @(posedge sys_clk_i);
      m.quiet;
      cmp("busy", 0, busy_o);
      cmp("resp", 0, agent_addr_response_out_o);
    end
  endtask
  task rd(input [4:0] o, input [39:0] a, input g, input [1:0] s,
      input [1:0] r, input pb, input [2:0] n);
    integer i;
    begin
      go(o, a, g, s, r, pb);
      cmp("status", exp_st(o, a, pb), st);
      settle;
      cmp("nbeats", n, m.rq.size());
      for (i = 0; i < m.rq.size(); i = i + 1) begin
        blk = mem[a[13:6]];
        cmp("beat", {tg, blk[128*((a[5:4]+i)%4) +: 128]}, m.rq[i]);
      end
    end
  endtask
  task wr(input [4:0] o, input [39:0] a, input [1:0] r);
    integer j;
    begin
      go(o, a, 1'b0, 2'h0, r, 1'b0);
      cmp("status", `SBMT_ST_ACK, st);
      for (j = 0; j < 16; j = j + 1) begin
        lf = lfsr(lf);
        blk = {blk[479:0], lf};
      end
      if (r == 2'h0) m.wbeats(tg, a[5:4], blk);
      if (r == 2'h0) mem[a[13:6]] = blk;
      settle;
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // cut a hang short
  always @(posedge sys_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      close_out;
    end
  end
  // ========
  // scenarios
  initial begin
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    cmp("strobe", 0, data_valid_strobe_o);
    for (k = 0; k < 6; k = k + 1) begin
      lf = lfsr(lf);
      ad = {26'h0, lf[7:0], lf[9:8], 4'h0};
      wr(5'h03 + k % 3, ad, 2'h0);
      lf = lfsr(lf);
      rd(5'h01 + k % 2, {ad[39:6], lf[1:0], 4'h0}, k[0], 0, 0, 0, 4);
    end
    wr(`SBMT_OP_WR_FLUSH, ad, `SBMT_RS_RETRY);
    rd(`SBMT_OP_READ, ad, 1'b0, 2'h0, 2'h0, 1'b0, 3'h4);
    for (k = 1; k < 4; k = k + 1)
      rd(`SBMT_OP_READ, ad, 1'b1, 2'h0, k[1:0], 1'b0, 1'b0);
    rd(`SBMT_OP_READ, ad, 1'b1, `SBMT_ST_RETRY, 0, 0, 0);
    rd(`SBMT_OP_READ, ad, 1'b0, 2'h0, 2'h0, 1'b1, 1'b0);
    for (k = 0; k < 10; k = k + 1)
      if (k == 0 || k > 5) rd(k, ad, 0, 0, 0, 0, 0);
    rd(`SBMT_OP_RFO, ad | 40'h10_0000, 0, 0, 0, 0, 0);
    // unguarded read killed by the response: beats before the abort only
    rd(`SBMT_OP_READ, ad, 1'b0, 2'h0, `SBMT_RS_RETRY, 1'b0,
      `SBMT_ABORT_DLY - 3'h1);
    rd(`SBMT_OP_READ, ad, 1'b0, `SBMT_ST_PARERR, 0, 0, 0);
    // acknowledge and parity checking switched off while idle
    @(negedge sys_clk_i);
    pos_ack_en_i = 1'b0;
    par_check_en_i = 1'b0;
    rd(`SBMT_OP_READ, ad, 1'b0, 2'h0, 2'h0, 1'b1, 3'h4);
    @(negedge sys_clk_i);
    pos_ack_en_i = 1'b1;
    par_check_en_i = 1'b1;
    m.tenure(`SBMT_OP_READ, ad, 8'h5a, 1'b0, 2'h0, 2'h0, 1'b0);
    repeat (3) @(posedge sys_clk_i);
    go(`SBMT_OP_READ, ad, 1'b0, 2'h0, 2'h0, 1'b0);
    cmp("status", `SBMT_ST_RETRY, st);
    settle;
    cmp("nbeats", 4, m.rq.size());
    close_out;
  end
endmodule // sbmt_mem_target_tb
